/* File: rtl/cpu_mode_params.svh */
// Constants for the status word, boot mode decode and address folding.
`ifndef CPU_MODE_PARAMS_SVH
`define CPU_MODE_PARAMS_SVH
`define SR_NUM_CAUSE 5'h04
`define SR_NUM_STATUS 5'h05
`define STATUS_BIT_NMI 7
`define STATUS_BIT_FAULT 6
`define STATUS_BIT_IDIS 5
`define STATUS_BIT_CLAMP 4
`define STATUS_BIT_CARRY 3
`define STATUS_BIT_WRAP 2
`define STATUS_BIT_SIGN 1
`define STATUS_BIT_ZERO 0
`define STATUS_LIVE_MASK 32'h0000_00ff
`define STATUS_RESET 8'h20
`define CAUSE_RESET 32'h0000_0000
`define PHYS_ADDR_W 26
`define ROM_BASE_LOW 26'h000_0000
`define ROM_BASE_HIGH 26'h010_0000
`define ROM_SPAN_MASK 26'h3f0_0000
`define ROM_RESET_ENTRY 26'h000_0000
`define EXT_RESET_ENTRY 26'h000_0000
`endif

/* File: rtl/cpu_mode_pkg.sv */
// Types shared by the status word and mode decode logic.
package cpu_mode_pkg;
   typedef enum logic [2:0] {
      MODE_ROMLESS0,
      MODE_ROMLESS1,
      MODE_SINGLE0,
      MODE_SINGLE1,
      MODE_FLASH_PROG,
      MODE_PROHIBITED
   } boot_mode_e;
   typedef enum logic [1:0] {
      BUS_NONE,
      BUS_8,
      BUS_16
   } bus_width_e;
endpackage

/* File: rtl/boot_mode_decode.sv */
// Decodes boot_select pins into operating mode and bus configuration.
`timescale 1ns/10ps
`include "cpu_mode_params.svh"
module boot_mode_decode (
   input wire logic [3:0] boot_select_pin_i, // Strap levels, pin 3 down to 0.
   input wire logic flash_vpp_high_i, // Pin 3 at programming voltage.
   output cpu_mode_pkg::boot_mode_e mode_o, // Decoded mode.
   output cpu_mode_pkg::bus_width_e width_o // External data bus width.
);
   always_comb begin
      mode_o = cpu_mode_pkg::MODE_PROHIBITED;
      width_o = cpu_mode_pkg::BUS_NONE;
      if (flash_vpp_high_i) begin
         if (boot_select_pin_i[2:0] == 3'h2) begin
            mode_o = cpu_mode_pkg::MODE_FLASH_PROG;
         end
      end else begin
         case (boot_select_pin_i)
            4'h0: begin
               mode_o = cpu_mode_pkg::MODE_ROMLESS0;
               width_o = cpu_mode_pkg::BUS_16;
            end
            4'h1: begin
               mode_o = cpu_mode_pkg::MODE_ROMLESS1;
               width_o = cpu_mode_pkg::BUS_8;
            end
            4'h2: mode_o = cpu_mode_pkg::MODE_SINGLE0;
            4'h3: begin
               mode_o = cpu_mode_pkg::MODE_SINGLE1;
               width_o = cpu_mode_pkg::BUS_16;
            end
            default: mode_o = cpu_mode_pkg::MODE_PROHIBITED;
         endcase
      end
   end
endmodule

/* File: rtl/addr_fold.sv */
// Folds a 32-bit CPU address onto the 26-bit physical space.
`timescale 1ns/10ps
`include "cpu_mode_params.svh"
module addr_fold (
   input wire logic [31:0] cpu_addr_i, // CPU address, data or program.
   input wire logic rom_enabled_i, // Internal ROM reachable.
   input wire logic [`PHYS_ADDR_W-1:0] rom_base_i, // Internal ROM base.
   output logic [`PHYS_ADDR_W-1:0] phys_addr_o, // Physical address.
   output logic rom_hit_o // Address lands in internal ROM.
);
   // The top six bits are dropped, so the space repeats 64 times.
   assign phys_addr_o = cpu_addr_i[`PHYS_ADDR_W-1:0];
   assign rom_hit_o = rom_enabled_i &&
      ((cpu_addr_i[`PHYS_ADDR_W-1:0] & `ROM_SPAN_MASK) == rom_base_i);
endmodule

/* File: rtl/cpu_mode_status.sv */
// Status word flags, cause register, boot mode latch and address folding.
// Behaviour
// - Status and cause registers are reached only by sysreg load/store with register number.
// - Status word bits 31 to 8 always read zero.
// - NMI acknowledge sets nmi_active_flag; while set, no interrupt is accepted.
// - Exception sets fault_in_progress_flag and interrupt_disable; the fault flag itself gates no interrupt.
// - interrupt_disable set blocks acknowledgement of maskable interrupts.
// - Saturating overflow sets clamp_overflow_flag; otherwise it holds, sticky.
// - carry_flag follows carry or borrow of each operation.
// - arith_wrap_flag follows overflow of each operation.
// - Sign bit follows a negative result.
// - Zero bit follows a zero result.
// - Operating mode comes from the four boot_select pins.
// - Single-chip 0: pins are ports, boot from internal ROM at 000000H.
// - External expansion enables only by writing memory_expansion_ctrl in single-chip 0.
// - Single-chip 1: control pins, external boot, ROM at 100000H, 16-bit bus.
// - ROMless modes: control pins, external boot, internal ROM unreachable.
// - ROMless 0 is LLLL with 16-bit bus; ROMless 1 is LLLH, 8-bit.
// - LLHL single-chip 0, LLHH single-chip 1, high-voltage LHL flash; rest prohibited.
// - Data uses 32-bit addresses; program space spans at most 64 MB.
// - Top 6 address bits are ignored, giving 64 images of 26-bit space.
// - Cause register: NMI code in upper 16 bits, interrupt code in lower.
`timescale 1ns/10ps
`include "cpu_mode_params.svh"
module cpu_mode_status (
   input wire logic clk_i, // Core clock, 200 MHz.
   input wire logic rst_i, // Asynchronous reset, active high.
   input wire logic ce_i, // Clock enable; low freezes all state.
   input wire logic [3:0] boot_select_pin_i, // Mode straps, pin 3 down to 0.
   input wire logic flash_vpp_high_i, // Pin 3 at programming voltage.
   input wire logic sr_load_i, // Sysreg load instruction strobe.
   input wire logic sr_store_i, // Sysreg store instruction strobe.
   input wire logic [4:0] sr_num_i, // System register number.
   input wire logic [31:0] sr_wdata_i, // Load data.
   input wire logic flags_upd_i, // Operation result updates flags.
   input wire logic res_carry_i, // Operation produced carry or borrow.
   input wire logic res_ovf_i, // Operation overflowed.
   input wire logic res_neg_i, // Result negative.
   input wire logic res_zero_i, // Result zero.
   input wire logic sat_op_i, // Operation is saturating.
   input wire logic nmi_req_i, // Non-maskable interrupt request.
   input wire logic [15:0] nmi_code_i, // NMI cause code.
   input wire logic int_req_i, // Maskable interrupt request.
   input wire logic [15:0] int_code_i, // Maskable interrupt cause code.
   input wire logic exc_req_i, // Exception raised.
   input wire logic [15:0] exc_code_i, // Exception cause code.
   input wire logic mem_expansion_wr_i, // Write to memory_expansion_ctrl.
   input wire logic mem_expansion_en_i, // Value written: expansion on.
   input wire logic [31:0] cpu_addr_i, // CPU address to fold.
   output logic [31:0] sr_rdata_o, // Store data.
   output logic nmi_ack_o, // NMI acknowledged, one cycle.
   output logic int_ack_o, // Maskable interrupt acknowledged, one cycle.
   output logic [2:0] boot_mode_o, // Latched operating mode.
   output logic [1:0] bus_width_o, // External data bus width code.
   output logic bus_ctrl_mode_o, // Bus pins in control function.
   output logic ext_expansion_o, // External expansion active.
   output logic [25:0] reset_entry_o, // Reset entry address.
   output logic [25:0] rom_base_o, // Internal ROM base address.
   output logic rom_enabled_o, // Internal ROM reachable.
   output logic [25:0] phys_addr_o, // Folded physical address.
   output logic rom_hit_o // Folded address is in internal ROM.
);
   logic [7:0] status_word;
   logic [7:0] next_status_word;
   logic [31:0] cause_reg;
   logic [31:0] next_cause_reg;
   logic [31:0] next_rdata;
   logic next_nmi_ack;
   logic next_int_ack;
   cpu_mode_pkg::boot_mode_e mode_dec;
   cpu_mode_pkg::bus_width_e width_dec;
   cpu_mode_pkg::boot_mode_e mode_q;
   cpu_mode_pkg::boot_mode_e next_mode_q;
   cpu_mode_pkg::bus_width_e width_q;
   cpu_mode_pkg::bus_width_e next_width_q;
   logic strap_taken;
   logic next_strap_taken;
   logic expansion;
   logic next_expansion;
   logic [25:0] rom_base_q;
   logic [25:0] next_rom_base;
   logic rom_en_q;
   logic next_rom_en;
   logic [25:0] fold_addr;
   logic fold_hit;

   function automatic logic is_romless(input cpu_mode_pkg::boot_mode_e m);
      is_romless = (m == cpu_mode_pkg::MODE_ROMLESS0) || (m == cpu_mode_pkg::MODE_ROMLESS1);
   endfunction

   boot_mode_decode u_decode (
      .boot_select_pin_i(boot_select_pin_i),
      .flash_vpp_high_i(flash_vpp_high_i),
      .mode_o(mode_dec),
      .width_o(width_dec)
   );

   addr_fold u_fold (
      .cpu_addr_i(cpu_addr_i),
      .rom_enabled_i(rom_en_q),
      .rom_base_i(rom_base_q),
      .phys_addr_o(fold_addr),
      .rom_hit_o(fold_hit)
   );

   // Status word, cause register and interrupt acknowledge.
   always_comb begin
      next_status_word = status_word;
      next_cause_reg = cause_reg;
      next_nmi_ack = 1'b0;
      next_int_ack = 1'b0;
      next_rdata = sr_rdata_o;
      if (sr_load_i && sr_num_i == `SR_NUM_STATUS) begin
         next_status_word = sr_wdata_i[7:0];
      end else if (sr_load_i && sr_num_i == `SR_NUM_CAUSE) begin
         next_cause_reg = sr_wdata_i;
      end
      // Flag updates and hardware events come after software loads, so a bit that
      // hardware sets in the same cycle as a load is never lost.
      if (flags_upd_i) begin
         next_status_word[`STATUS_BIT_CARRY] = res_carry_i;
         next_status_word[`STATUS_BIT_WRAP] = res_ovf_i;
         next_status_word[`STATUS_BIT_SIGN] = res_neg_i;
         next_status_word[`STATUS_BIT_ZERO] = res_zero_i;
         if (sat_op_i && res_ovf_i) begin
            next_status_word[`STATUS_BIT_CLAMP] = 1'b1;
         end
      end
      if (nmi_req_i && !status_word[`STATUS_BIT_NMI]) begin
         next_nmi_ack = 1'b1;
         next_status_word[`STATUS_BIT_NMI] = 1'b1;
         next_status_word[`STATUS_BIT_IDIS] = 1'b1;
         next_cause_reg[31:16] = nmi_code_i;
      end else if (exc_req_i) begin
         next_status_word[`STATUS_BIT_FAULT] = 1'b1;
         next_status_word[`STATUS_BIT_IDIS] = 1'b1;
         next_cause_reg[15:0] = exc_code_i;
      end else if (int_req_i && !status_word[`STATUS_BIT_NMI] &&
         !status_word[`STATUS_BIT_IDIS]) begin
         // Fault-in-progress does not gate this path.
         next_int_ack = 1'b1;
         next_status_word[`STATUS_BIT_IDIS] = 1'b1;
         next_cause_reg[15:0] = int_code_i;
      end
      if (sr_store_i) begin
         case (sr_num_i)
            `SR_NUM_STATUS: next_rdata = {24'h00_0000, status_word};
            `SR_NUM_CAUSE: next_rdata = cause_reg;
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_word <= `STATUS_RESET;
         cause_reg <= `CAUSE_RESET;
         sr_rdata_o <= 32'h0000_0000;
         nmi_ack_o <= 1'b0;
         int_ack_o <= 1'b0;
      end else if (ce_i) begin
         status_word <= next_status_word;
         cause_reg <= next_cause_reg;
         sr_rdata_o <= next_rdata;
         nmi_ack_o <= next_nmi_ack;
         int_ack_o <= next_int_ack;
      end
   end

   // Straps are sampled once after reset; later changes are not tracked
   // because the board must hold them fixed.
   always_comb begin
      next_mode_q = mode_q;
      next_width_q = width_q;
      next_strap_taken = strap_taken;
      next_expansion = expansion;
      next_rom_base = rom_base_q;
      next_rom_en = rom_en_q;
      if (!strap_taken) begin
         next_strap_taken = 1'b1;
         next_mode_q = mode_dec;
         next_width_q = width_dec;
         next_rom_en = !is_romless(mode_dec);
         next_rom_base = (mode_dec == cpu_mode_pkg::MODE_SINGLE1) ?
            `ROM_BASE_HIGH : `ROM_BASE_LOW;
      end else if (mem_expansion_wr_i && mode_q == cpu_mode_pkg::MODE_SINGLE0) begin
         next_expansion = mem_expansion_en_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= cpu_mode_pkg::MODE_PROHIBITED;
         width_q <= cpu_mode_pkg::BUS_NONE;
         strap_taken <= 1'b0;
         expansion <= 1'b0;
         rom_base_q <= `ROM_BASE_LOW;
         rom_en_q <= 1'b0;
      end else if (ce_i) begin
         mode_q <= next_mode_q;
         width_q <= next_width_q;
         strap_taken <= next_strap_taken;
         expansion <= next_expansion;
         rom_base_q <= next_rom_base;
         rom_en_q <= next_rom_en;
      end
   end

   // Mode-derived and folded-address outputs, registered one cycle behind the latched mode and the CPU address.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         boot_mode_o <= 3'h5;
         bus_width_o <= 2'h0;
         bus_ctrl_mode_o <= 1'b0;
         ext_expansion_o <= 1'b0;
         reset_entry_o <= `ROM_RESET_ENTRY;
         rom_base_o <= `ROM_BASE_LOW;
         rom_enabled_o <= 1'b0;
         phys_addr_o <= 26'h000_0000;
         rom_hit_o <= 1'b0;
      end else if (ce_i) begin
         boot_mode_o <= mode_q;
         bus_width_o <= width_q;
         bus_ctrl_mode_o <= (mode_q != cpu_mode_pkg::MODE_SINGLE0) &&
            (mode_q != cpu_mode_pkg::MODE_PROHIBITED);
         // Expansion comes only from the control write taken in single-chip 0.
         ext_expansion_o <= expansion;
         reset_entry_o <= (mode_q == cpu_mode_pkg::MODE_SINGLE0) ?
            `ROM_RESET_ENTRY : `EXT_RESET_ENTRY;
         rom_base_o <= rom_base_q;
         rom_enabled_o <= rom_en_q;
         phys_addr_o <= fold_addr;
         rom_hit_o <= fold_hit;
      end
   end
endmodule

/* File: tb/strap_board.sv */
// Board strapping model that feeds the boot select pins.
`timescale 1ns/10ps
module strap_board (
   input wire logic rst_i, // Board reset.
   input wire logic [4:0] want_i, // Wanted straps, bit 4 is high voltage.
   output logic [3:0] boot_select_pin_o, // Strap levels.
   output logic flash_vpp_high_o // Pin 3 at programming voltage.
);
   // The straps only move while reset is held, so a running part never sees a change.
   always_latch begin
      if (rst_i) begin
         {flash_vpp_high_o, boot_select_pin_o} <= want_i;
      end
   end
endmodule

/* File: tb/cpu_mode_status_sva.sv */
// Concurrent checks on the status, mode and address outputs.
`timescale 1ns/10ps
`include "cpu_mode_params.svh"
module cpu_mode_status_sva (
   input wire logic clk_i, // Clock.
   input wire logic rst_i, // Reset.
   input wire logic ce_i, // Enable.
   input wire logic sr_store_i, // Store.
   input wire logic [4:0] sr_num_i, // Number.
   input wire logic [31:0] sr_rdata_o, // Store data.
   input wire logic nmi_ack_o, // NMI ack.
   input wire logic int_ack_o, // Interrupt ack.
   input wire logic [2:0] boot_mode_o, // Mode.
   input wire logic [1:0] bus_width_o, // Width.
   input wire logic bus_ctrl_mode_o, // Control pins.
   input wire logic ext_expansion_o, // Expansion.
   input wire logic [25:0] rom_base_o, // ROM base.
   input wire logic rom_enabled_o, // ROM on.
   input wire logic [31:0] cpu_addr_i, // Address.
   input wire logic [25:0] phys_addr_o // Folded address.
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   rsvd_zero_a: assert property (sr_store_i && ce_i && sr_num_i == `SR_NUM_STATUS
      |=> sr_rdata_o[31:8] == 24'h0) else $error("status upper bits not zero");
   nmi_nest_a: assert property (nmi_ack_o |=> !nmi_ack_o && !int_ack_o)
      else $error("nested interrupt accepted");
   int_mask_a: assert property (int_ack_o |=> !int_ack_o)
      else $error("interrupt accepted while disabled");
   romless_pins_a: assert property (boot_mode_o < 3'h2
      |-> !rom_enabled_o && bus_ctrl_mode_o) else $error("romless mode setup wrong");
   romless_width_a: assert property (boot_mode_o < 3'h2
      |-> bus_width_o == (boot_mode_o[0] ? 2'h1 : 2'h2)) else $error("romless width wrong");
   single_one_a: assert property (boot_mode_o == 3'h3 |-> rom_base_o == `ROM_BASE_HIGH
      && bus_ctrl_mode_o && bus_width_o == 2'h2) else $error("single-chip 1 setup wrong");
   single_zero_a: assert property (boot_mode_o == 3'h2 |-> rom_base_o == `ROM_BASE_LOW
      && !bus_ctrl_mode_o && rom_enabled_o) else $error("single-chip 0 setup wrong");
   addr_fold_a: assert property (ce_i |=> phys_addr_o == $past(cpu_addr_i[25:0]))
      else $error("address fold wrong");
   expand_mode_a: assert property (ext_expansion_o |-> boot_mode_o == 3'h2)
      else $error("expansion outside single-chip 0");
   cover property (nmi_ack_o);
   cover property (int_ack_o);
   cover property (ext_expansion_o);
endmodule
bind cpu_mode_status cpu_mode_status_sva u_cpu_mode_status_sva (.*);

/* File: tb/tb_cpu_mode_status.sv */
// Self-checking bench for the status word, mode decode and address folding.
`timescale 1ns/10ps
`include "cpu_mode_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_cpu_mode_status;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, flash_vpp_high_i;
   logic sr_load_i = 1'b0, sr_store_i = 1'b0, flags_upd_i = 1'b0, sat_op_i = 1'b0;
   logic res_carry_i = 1'b0, res_ovf_i = 1'b0, res_neg_i = 1'b0, res_zero_i = 1'b0;
   logic nmi_req_i = 1'b0, int_req_i = 1'b0, exc_req_i = 1'b0;
   logic mem_expansion_wr_i = 1'b0, mem_expansion_en_i = 1'b0;
   logic nmi_ack_o, int_ack_o, bus_ctrl_mode_o, ext_expansion_o, rom_enabled_o, rom_hit_o;
   logic [1:0] bus_width_o;
   logic [2:0] boot_mode_o, m;
   logic [3:0] boot_select_pin_i;
   logic [4:0] sr_num_i = 5'h00, want = 5'h02;
   logic [15:0] nmi_code_i = 16'h0, int_code_i = 16'h0, exc_code_i = 16'h0;
   logic [25:0] reset_entry_o, rom_base_o, phys_addr_o;
   logic [31:0] sr_wdata_i = 32'h0, cpu_addr_i = 32'h0, sr_rdata_o, exp_status, cause, a;
   logic [4:0] straps [6] = '{5'h00, 5'h01, 5'h03, 5'h1a, 5'h08, 5'h02};
   int ld [7] = '{0, -1, 'h40, -1, 'h80, -1, 0};
   int kd [7] = '{0, 0, 0, 1, 0, 1, 2};
   int seed = 46755, err_total = 0, check_count = 0, cyc = 0;
   int nmi_n = 0, int_n = 0, exp_nmi = 0, exp_int = 0;
   strap_board u_strap_board (.rst_i(rst_i), .want_i(want), .boot_select_pin_o(boot_select_pin_i),
      .flash_vpp_high_o(flash_vpp_high_i));
   cpu_mode_status u_cpu_mode_status (.*);
   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      nmi_n += nmi_ack_o;
      int_n += int_ack_o;
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (err_total == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic sr(input logic ldg, input logic [4:0] n, input logic [31:0] d);
      @(negedge clk_i);
      {sr_load_i, sr_store_i, sr_num_i, sr_wdata_i} = {ldg, !ldg, n, d};
      @(negedge clk_i);
      {sr_load_i, sr_store_i} = 2'h0;
   endtask
   task automatic restart(input logic [4:0] w);
      @(negedge clk_i);
      {rst_i, want} = {1'b1, w};
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge clk_i);
      exp_status = `STATUS_RESET;
      cause = `CAUSE_RESET;
   endtask
   // Acks are counted rather than sampled, so the check does not hang on their exact cycle.
   task automatic ev(input int k, input logic [15:0] c);
      @(negedge clk_i);
      {exc_req_i, nmi_req_i, int_req_i} = 3'h1 << k;
      {exc_code_i, nmi_code_i, int_code_i} = {3{c}};
      @(negedge clk_i);
      {exc_req_i, nmi_req_i, int_req_i} = 3'h0;
      if (k == 1 && !exp_status[7]) begin
         exp_status = exp_status | 32'ha0;
         cause[31:16] = c;
         exp_nmi++;
      end else if (k == 2) begin
         exp_status = exp_status | 32'h60;
         cause[15:0] = c;
      end else if (k == 0 && !exp_status[7] && !exp_status[5]) begin
         exp_status = exp_status | 32'h20;
         cause[15:0] = c;
         exp_int++;
      end
      sr(1'b0, `SR_NUM_STATUS, 32'h0);
      `CHK(sr_rdata_o, exp_status)
      sr(1'b0, `SR_NUM_CAUSE, 32'h0);
      `CHK(sr_rdata_o, cause)
      `CHK(nmi_n, exp_nmi)
      `CHK(int_n, exp_int)
   endtask
   initial begin
      for (int i = 0; i < 6; i++) begin
         restart(straps[i]);
         m = straps[i] == 5'h1a ? 3'h4 : straps[i] > 5'h03 ? 3'h5 : straps[i][2:0];
         `CHK(boot_mode_o, m)
         `CHK(bus_width_o, m == 3'h1 ? 2'h1 : (m == 3'h0 || m == 3'h3) ? 2'h2 : 2'h0)
         `CHK(bus_ctrl_mode_o, m != 3'h2 && m != 3'h5)
         `CHK(rom_enabled_o, m > 3'h1)
         `CHK(rom_base_o, m == 3'h3 ? `ROM_BASE_HIGH : `ROM_BASE_LOW)
         `CHK(reset_entry_o, m == 3'h2 ? `ROM_RESET_ENTRY : `EXT_RESET_ENTRY)
         sr(1'b0, `SR_NUM_STATUS, 32'h0);
         `CHK(sr_rdata_o, exp_status)
         @(negedge clk_i);
         {mem_expansion_wr_i, mem_expansion_en_i} = 2'h3;
         // An upper image of the relocated ROM base; only single-chip 1 may hit it.
         cpu_addr_i = 32'h0410_0000;
         @(negedge clk_i);
         mem_expansion_wr_i = 1'b0;
         repeat (2) @(negedge clk_i);
         `CHK(ext_expansion_o, m == 3'h2)
         `CHK(rom_hit_o, m == 3'h3)
      end
      for (int i = 0; i < 40; i++) begin
         a = $random(seed);
         @(negedge clk_i);
         {res_carry_i, res_ovf_i, res_neg_i, res_zero_i, sat_op_i, flags_upd_i} = {a[4:0], 1'b1};
         cpu_addr_i = a;
         @(negedge clk_i);
         flags_upd_i = 1'b0;
         exp_status[3:0] = a[4:1];
         exp_status[4] = exp_status[4] | (a[0] & a[3]);
         `CHK(phys_addr_o, a[25:0])
         sr(1'b0, `SR_NUM_STATUS, 32'h0);
         `CHK(sr_rdata_o, exp_status)
      end
      // A flag update offered while the clock enable is low must leave the word alone.
      @(negedge clk_i);
      {ce_i, flags_upd_i, sat_op_i, res_ovf_i, res_carry_i} = 5'h0f;
      @(negedge clk_i);
      {ce_i, flags_upd_i, sat_op_i, res_ovf_i, res_carry_i} = 5'h10;
      sr(1'b0, `SR_NUM_STATUS, 32'h0);
      `CHK(sr_rdata_o, exp_status)
      a = $random(seed);
      sr(1'b1, `SR_NUM_STATUS, a);
      sr(1'b1, 5'h06, ~a);
      sr(1'b0, `SR_NUM_STATUS, 32'h0);
      `CHK(sr_rdata_o, a & `STATUS_LIVE_MASK)
      sr(1'b0, 5'h06, 32'h0);
      `CHK(sr_rdata_o, 32'h0)
      for (int i = 0; i < 7; i++) begin
         if (ld[i] >= 0) begin
            sr(1'b1, `SR_NUM_STATUS, ld[i]);
            exp_status = ld[i];
         end
         ev(kd[i], $random(seed));
      end
      stop_test();
   end
endmodule
